/* hdl/nvm_cfg_pkg.sv */
/*
 * shared constants and types for the nonvolatile configuration loader.
 * assumes a byte-wide register access port decoded by the serial control port.
 */
`default_nettype none
package nvm_cfg_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [11:0] DESC_FIRST_ADDR   = 12'h0a00;
   localparam logic [11:0] DESC_LAST_ADDR    = 12'h0a16;
   localparam logic [11:0] BUSY_ADDR         = 12'h0b00;
   localparam logic [11:0] ERROR_ADDR        = 12'h0b01;
   localparam logic [11:0] RELOAD_WREN_ADDR  = 12'h0b02;
   localparam logic [11:0] STORE_ADDR        = 12'h0b03;
   localparam int          DESC_COUNT        = 23;
   localparam int          WREN_BIT          = 0;
   localparam int          RELOAD_BIT        = 1;
   localparam int          STORE_BIT         = 0;
   localparam int          BUSY_BIT          = 0;
   localparam int          ERROR_BIT         = 0;
   // ****************************************************************
   // descriptor encoding: bit 7 set marks an opcode, else the byte count less one
   // ****************************************************************
   localparam logic [7:0]  OP_MARK           = 8'h80;
   localparam logic [7:0]  OP_APPLY          = 8'h80;
   localparam logic [7:0]  OP_END            = 8'hff;
   localparam logic [7:0]  ZERO_BYTE         = 8'h00;
   localparam logic [7:0]  DEF_COUNT         = 8'h7f;
   localparam logic [7:0]  DEF_ADDR_HI       = 8'h00;
   localparam logic [7:0]  DEF_ADDR_LO       = 8'h00;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } reg_req_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;
endpackage : nvm_cfg_pkg
`default_nettype wire

/* hdl/nvm_walk_fsm.sv */
/*
 * descriptor walker: steps through descriptor bytes and moves bytes
 * between the buffer bank and the nonvolatile memory.
 * assumes the memory and the buffer answer reads in the next cycle.
 */
`default_nettype none
module nvm_walk_fsm
   import nvm_cfg_pkg::*;
(
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         start_i,
   input  wire logic         to_nvm_i,
   input  wire logic [7:0]   desc_byte_i,
   output logic      [4:0]   desc_idx_o,
   output mem_req_t          mem_req_o,
   input  wire logic [7:0]   mem_rdata_i,
   input  wire logic         mem_err_i,
   output mem_req_t          buf_req_o,
   input  wire logic [7:0]   buf_rdata_i,
   output logic              apply_o,
   output logic              done_o,
   output logic              err_o
);
   typedef enum logic [5:0] {
      S_IDLE  = 6'b000001,
      S_CNT   = 6'b000010,
      S_AHI   = 6'b000100,
      S_ALO   = 6'b001000,
      S_RD    = 6'b010000,
      S_WR    = 6'b100000
   } walk_t;

   walk_t       state_reg;
   walk_t       state_next;
   logic [4:0]  idx_reg;
   logic [7:0]  cnt_reg;
   logic [11:0] addr_reg;
   logic [11:0] nvm_ptr_reg;
   logic        err_reg;
   logic        is_op;

   assign is_op      = (desc_byte_i & OP_MARK) != ZERO_BYTE;
   assign desc_idx_o = idx_reg;
   assign err_o      = err_reg;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: if (start_i) state_next = S_CNT;
         S_CNT:  if (is_op && desc_byte_i == OP_END) state_next = S_IDLE;
                 else if (is_op) state_next = S_CNT;
                 else state_next = S_AHI;
         S_AHI:  state_next = S_ALO;
         S_ALO:  state_next = S_RD;
         S_RD:   state_next = S_WR;
         S_WR:   state_next = (cnt_reg == ZERO_BYTE) ? S_CNT : S_RD;
         default: state_next = S_IDLE;
      endcase
   end

   // ****************************************************************
   // datapath
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg   <= S_IDLE;
         idx_reg     <= '0;
         cnt_reg     <= ZERO_BYTE;
         addr_reg    <= '0;
         nvm_ptr_reg <= '0;
         err_reg     <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == S_IDLE && start_i)
         begin
            idx_reg     <= '0;
            nvm_ptr_reg <= '0;
            err_reg     <= 1'b0;
         end
         else if (state_reg == S_CNT || state_reg == S_AHI || state_reg == S_ALO)
         begin
            idx_reg <= idx_reg + 5'd1;
         end
         if (state_reg == S_CNT)
            cnt_reg <= desc_byte_i;
         if (state_reg == S_AHI)
            addr_reg[11:8] <= desc_byte_i[3:0];
         if (state_reg == S_ALO)
            addr_reg[7:0] <= desc_byte_i;
         if (state_reg == S_WR)
         begin
            addr_reg    <= addr_reg + 12'h001;
            nvm_ptr_reg <= nvm_ptr_reg + 12'h001;
            cnt_reg     <= cnt_reg - 8'h01;
         end
         if (state_reg == S_WR && mem_err_i)
            err_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // memory and buffer strobes
   // ****************************************************************
   always_comb
   begin
      mem_req_o       = '0;
      buf_req_o       = '0;
      mem_req_o.addr  = nvm_ptr_reg;
      buf_req_o.addr  = addr_reg;
      mem_req_o.rd    = (state_reg == S_RD) && !to_nvm_i;
      buf_req_o.rd    = (state_reg == S_RD) && to_nvm_i;
      mem_req_o.wr    = (state_reg == S_WR) && to_nvm_i;
      buf_req_o.wr    = (state_reg == S_WR) && !to_nvm_i;
      mem_req_o.wdata = buf_rdata_i;
      buf_req_o.wdata = mem_rdata_i;
   end

   // opcode executes while walking
   assign apply_o = (state_reg == S_CNT) && is_op && desc_byte_i == OP_APPLY;
   assign done_o  = (state_reg == S_CNT) && is_op && desc_byte_i == OP_END;
endmodule : nvm_walk_fsm
`default_nettype wire

/* hdl/nvm_config_store_loader.sv */
/*
 * configuration store and reload controller with its control registers.
 * assumes a decoded byte register port from the serial control port,
 * synchronous to core_clk_i, and a rising-edge pulse of the serial clock.
 */
`default_nettype none
module nvm_config_store_loader
   import nvm_cfg_pkg::*;
(
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire reg_req_t     reg_req_i,
   output logic      [7:0]   reg_rdata_o,
   input  wire logic         status_sel_i,
   output logic              status_pin_o,
   input  wire logic         mem_sel_pin_i,
   input  wire logic         sclk_rise_i,
   input  wire logic         apply_req_i,
   output logic              apply_regs_o,
   output logic              soft_reset_o,
   output mem_req_t          mem_req_o,
   input  wire logic [7:0]   mem_rdata_i,
   input  wire logic         mem_err_i,
   output mem_req_t          buf_req_o,
   input  wire logic [7:0]   buf_rdata_i
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0]  desc_reg [DESC_COUNT];
   logic        wren_reg;
   logic        store_reg;
   logic        reload_reg;
   logic        busy_reg;
   logic        to_nvm_reg;
   logic        apply_pend_reg;
   logic        apply_out_reg;
   logic        sel_s1_reg;
   logic        sel_s2_reg;
   logic [7:0]  rdata_reg;
   logic        status_reg;
   logic [4:0]  desc_idx;
   logic        walk_done;
   logic        walk_apply;
   logic        walk_err;
   logic        walk_start;
   logic        wr_desc;
   logic        wr_ctrl;
   logic        wr_store;
   logic        start_store;
   logic        start_reload;
   logic [11:0] desc_off;
   logic [7:0]  desc_sel;

   default clocking cb_core @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   assign desc_off     = reg_req_i.addr - DESC_FIRST_ADDR;
   assign wr_desc      = reg_req_i.wr && reg_req_i.addr >= DESC_FIRST_ADDR
                         && reg_req_i.addr <= DESC_LAST_ADDR;
   assign wr_ctrl      = reg_req_i.wr && reg_req_i.addr == RELOAD_WREN_ADDR;
   assign wr_store     = reg_req_i.wr && reg_req_i.addr == STORE_ADDR;
   // a store without write enable is dropped, the memory stays protected
   assign start_store  = wr_store && reg_req_i.wdata[STORE_BIT] && wren_reg
                         && !busy_reg;
   // pin passes two flops first; a high pin blocks the reload
   assign start_reload = wr_ctrl && reg_req_i.wdata[RELOAD_BIT] && !sel_s2_reg
                         && !busy_reg;
   assign walk_start   = start_store || start_reload;
   assign desc_sel     = (desc_idx < 5'(DESC_COUNT)) ? desc_reg[desc_idx] : OP_END;

   nvm_walk_fsm u_walk (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .start_i     (walk_start),
      .to_nvm_i    (to_nvm_reg),
      .desc_byte_i (desc_sel),
      .desc_idx_o  (desc_idx),
      .mem_req_o   (mem_req_o),
      .mem_rdata_i (mem_rdata_i),
      .mem_err_i   (mem_err_i),
      .buf_req_o   (buf_req_o),
      .buf_rdata_i (buf_rdata_i),
      .apply_o     (walk_apply),
      .done_o      (walk_done),
      .err_o       (walk_err)
   );

   // ****************************************************************
   // descriptor bank with a default of one 128-byte copy from 0x000, then apply
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < DESC_COUNT; gi++)
      begin : g_desc
         localparam logic [7:0] DEF = (gi == 0) ? DEF_COUNT :
                                      (gi == 1) ? DEF_ADDR_HI :
                                      (gi == 2) ? DEF_ADDR_LO :
                                      (gi == 3) ? OP_APPLY : OP_END;
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
               desc_reg[gi] <= DEF;
            else if (wr_desc && desc_off == 12'(gi))
               desc_reg[gi] <= reg_req_i.wdata;
         end
      end
   endgenerate

   // ****************************************************************
   // control and status
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         wren_reg   <= 1'b0;
         store_reg  <= 1'b0;
         reload_reg <= 1'b0;
         busy_reg   <= 1'b0;
         to_nvm_reg <= 1'b0;
         sel_s1_reg <= 1'b1;
         sel_s2_reg <= 1'b1;
      end
      else
      begin
         sel_s1_reg <= mem_sel_pin_i;
         sel_s2_reg <= sel_s1_reg;
         if (wr_ctrl)
            wren_reg <= reg_req_i.wdata[WREN_BIT];
         if (walk_start)
         begin
            busy_reg   <= 1'b1;
            to_nvm_reg <= start_store;
            store_reg  <= start_store;
            reload_reg <= start_reload;
         end
         else if (walk_done)
         begin
            busy_reg   <= 1'b0;
            store_reg  <= 1'b0;
            reload_reg <= 1'b0;
         end
      end
   end

   // pulse the reset when a reload starts; reload walk then fills the buffer
   assign soft_reset_o = start_reload;

   // ****************************************************************
   // apply buffer to active registers on serial clock rise
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         apply_pend_reg <= 1'b0;
         apply_out_reg  <= 1'b0;
      end
      else
      begin
         apply_out_reg <= apply_pend_reg && sclk_rise_i;
         if (apply_req_i || walk_apply)
            apply_pend_reg <= 1'b1;
         else if (sclk_rise_i)
            apply_pend_reg <= 1'b0;
      end
   end
   assign apply_regs_o = apply_out_reg;

   // ****************************************************************
   // readback and status pin
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         rdata_reg  <= ZERO_BYTE;
         status_reg <= 1'b0;
      end
      else
      begin
         status_reg <= status_sel_i && busy_reg;
         if (reg_req_i.rd)
         begin
            rdata_reg <= ZERO_BYTE;
            if (reg_req_i.addr >= DESC_FIRST_ADDR && reg_req_i.addr <= DESC_LAST_ADDR)
               rdata_reg <= desc_reg[desc_off[4:0]];
            else if (reg_req_i.addr == BUSY_ADDR)
               rdata_reg[BUSY_BIT] <= busy_reg;
            else if (reg_req_i.addr == ERROR_ADDR)
               rdata_reg[ERROR_BIT] <= walk_err;
            else if (reg_req_i.addr == RELOAD_WREN_ADDR)
               rdata_reg <= {6'h00, reload_reg, wren_reg};
            else if (reg_req_i.addr == STORE_ADDR)
               rdata_reg[STORE_BIT] <= store_reg;
         end
      end
   end
   assign reg_rdata_o  = rdata_reg;
   assign status_pin_o = status_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_STORE_NEEDS_WREN: assert property (
      (wr_store && reg_req_i.wdata[STORE_BIT] && !wren_reg && !busy_reg) |=> !busy_reg)
      else $error("store began without write enable");
   AST_BUSY_ON_START: assert property (
      walk_start |=> busy_reg)
      else $error("busy not set at start");
   AST_DONE_CLEARS: assert property (
      (walk_done && busy_reg) |=> !busy_reg && !store_reg)
      else $error("store trigger stayed after done");
   AST_STATUS_PIN: assert property (
      1'b1 |=> status_pin_o == ($past(status_sel_i) && $past(busy_reg)))
      else $error("status pin wrong");
   AST_APPLY_EDGE: assert property (
      apply_regs_o |-> $past(sclk_rise_i))
      else $error("apply without serial edge");
   AST_RELOAD_PIN: assert property (
      soft_reset_o |-> !sel_s2_reg)
      else $error("reload with pin high");
   AST_ERR_CLEAR: assert property (
      walk_start |=> !walk_err)
      else $error("error not cleared at start");
   AST_BUSY_READ: assert property (
      (reg_req_i.rd && reg_req_i.addr == BUSY_ADDR)
         |=> reg_rdata_o[BUSY_BIT] == $past(busy_reg))
      else $error("busy readback wrong");

   // ****************************************************************
   // walk sequences
   // ****************************************************************
   // a refused request must leave no trace, so each start is checked both ways
   sequence seq_store_req;
      wr_store && reg_req_i.wdata[STORE_BIT] && wren_reg && !busy_reg;
   endsequence
   sequence seq_reload_req;
      wr_ctrl && reg_req_i.wdata[RELOAD_BIT] && !sel_s2_reg && !busy_reg;
   endsequence
   sequence seq_walk_store;
      busy_reg && store_reg && to_nvm_reg;
   endsequence
   sequence seq_walk_reload;
      busy_reg && reload_reg && !store_reg && !to_nvm_reg;
   endsequence

   AST_STORE_STARTS: assert property (
      seq_store_req |=> seq_walk_store)
      else $error("store did not start");
   AST_RELOAD_STARTS: assert property (
      seq_reload_req |-> soft_reset_o ##1 seq_walk_reload)
      else $error("reload did not start");
   AST_RELOAD_BLOCKED: assert property (
      (wr_ctrl && reg_req_i.wdata[RELOAD_BIT] && sel_s2_reg) |-> !soft_reset_o)
      else $error("reload ran with pin high");
   AST_BUSY_HOLDS: assert property (
      (busy_reg && !walk_done) |=> busy_reg)
      else $error("busy fell before end of data");
   AST_IDLE_HOLDS: assert property (
      (!busy_reg && !walk_start) |=> !busy_reg)
      else $error("busy rose without a start");
   AST_MEM_WR_GATED: assert property (
      mem_req_o.wr |-> seq_walk_store)
      else $error("memory written outside a store");
   AST_BUF_WR_GATED: assert property (
      buf_req_o.wr |-> seq_walk_reload)
      else $error("buffer written outside a reload");
   AST_STORE_READ: assert property (
      (reg_req_i.rd && reg_req_i.addr == STORE_ADDR)
         |=> reg_rdata_o[STORE_BIT] == $past(store_reg))
      else $error("store trigger readback wrong");
   AST_ERR_READ: assert property (
      (reg_req_i.rd && reg_req_i.addr == ERROR_ADDR)
         |=> reg_rdata_o[ERROR_BIT] == $past(walk_err))
      else $error("error readback wrong");
   AST_ERR_STICKY: assert property (
      (walk_err && !walk_start) |=> walk_err)
      else $error("error bit lost before next transfer");
   AST_APPLY_FOLLOWS: assert property (
      (apply_pend_reg && sclk_rise_i) |=> apply_regs_o)
      else $error("pending apply missed serial edge");
   AST_APPLY_CLEARS: assert property (
      (apply_pend_reg && sclk_rise_i && !apply_req_i && !walk_apply) |=> !apply_pend_reg)
      else $error("apply did not clear itself");
   AST_WALK_APPLY: assert property (
      walk_apply |=> apply_pend_reg)
      else $error("apply opcode not taken");
   AST_RELOAD_CLEARS: assert property (
      (walk_done && busy_reg) |=> !reload_reg)
      else $error("reload bit stayed after done");
   AST_STATUS_IDLE: assert property (
      !busy_reg |=> !status_pin_o)
      else $error("status pin high while idle");
   AST_WREN_WRITE: assert property (
      wr_ctrl |=> wren_reg == $past(reg_req_i.wdata[WREN_BIT]))
      else $error("write enable not taken");
endmodule : nvm_config_store_loader
`default_nettype wire

/* tb/nvm_mem_model.sv */
/*
 * model of the nonvolatile memory and the buffer register bank.
 * assumes one-cycle read latency and single-cycle strobes from the loader.
 */
`default_nettype none
module nvm_mem_model
   import nvm_cfg_pkg::*;
(
   input  wire logic       core_clk_i,
   input  var  mem_req_t   mem_req_i,
   output logic      [7:0] mem_rdata_o,
   input  var  mem_req_t   buf_req_i,
   output logic      [7:0] buf_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_q [4096];
   logic [7:0] buf_q [4096];

   initial
   begin
      mem_rdata_o = 8'h00;
      buf_rdata_o = 8'h00;
      for (int i = 0; i < 4096; i++)
      begin
         mem_q[i] = i[7:0] ^ 8'h5a;
         buf_q[i] = i[7:0];
      end
   end

   // idle read data toggles so a stale byte never passes for a fresh one
   always @(posedge core_clk_i)
   begin
      mem_rdata_o <= mem_req_i.rd ? mem_q[mem_req_i.addr] : ~mem_rdata_o;
      buf_rdata_o <= buf_req_i.rd ? buf_q[buf_req_i.addr] : ~buf_rdata_o;
      if (mem_req_i.wr)
         mem_q[mem_req_i.addr] <= mem_req_i.wdata;
      if (buf_req_i.wr)
         buf_q[buf_req_i.addr] <= buf_req_i.wdata;
   end
endmodule : nvm_mem_model
`default_nettype wire

/* tb/testbench.sv */
/*
 * self-checking bench for the configuration store and reload controller.
 * assumes the memory model answers reads one cycle after the strobe.
 */
`default_nettype none
`define CHECK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module testbench
   import nvm_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk, rst_n, status_sel, status_pin, mem_sel_pin, sclk_rise;
   logic       apply_req, apply_regs, soft_reset, mem_err;
   logic [7:0] rdata, mem_rdata, buf_rdata, v;
   reg_req_t   req;
   mem_req_t   mem_req, buf_req;
   int         n_mismatch = 0;
   int         checks = 0;
   int         n_apply = 0;
   int         n_sreset = 0;
   logic [11:0] row_addr [10] = '{12'h0a00, 12'h0a01, 12'h0a02, 12'h0a03, 12'h0a04,
                                  12'h0b00, 12'h0b01, 12'h0b02, 12'h0b03, 12'h0c00};
   logic [7:0]  row_exp  [10] = '{8'h7f, 8'h00, 8'h00, 8'h80, 8'hff,
                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   nvm_config_store_loader i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_req_i(req),
      .reg_rdata_o(rdata), .status_sel_i(status_sel), .status_pin_o(status_pin),
      .mem_sel_pin_i(mem_sel_pin), .sclk_rise_i(sclk_rise), .apply_req_i(apply_req),
      .apply_regs_o(apply_regs), .soft_reset_o(soft_reset), .mem_req_o(mem_req),
      .mem_rdata_i(mem_rdata), .mem_err_i(mem_err), .buf_req_o(buf_req),
      .buf_rdata_i(buf_rdata));
   nvm_mem_model i_nvm (.core_clk_i(core_clk), .mem_req_i(mem_req), .mem_rdata_o(mem_rdata),
      .buf_req_i(buf_req), .buf_rdata_o(buf_rdata));

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (apply_regs === 1'b1) n_apply++;
      if (soft_reset === 1'b1) n_sreset++;
   end

   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask : reg_wr

   task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge core_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      req <= '0;
      #1 d = rdata;
   endtask : reg_rd

   // polls busy with a bound; a stuck walk ends the run
   task automatic wait_idle();
      logic [7:0] b;
      for (int i = 0; i < 3000; i++)
      begin
         reg_rd(BUSY_ADDR, b);
         if (b[0] === 1'b0) return;
      end
      n_mismatch++;
      stop_test();
   endtask : wait_idle

   task automatic pulse_sclk();
      @(posedge core_clk);
      sclk_rise <= 1'b1;
      @(posedge core_clk);
      sclk_rise <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : pulse_sclk

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      req = '0; rst_n = 1'b0; status_sel = 1'b0; mem_sel_pin = 1'b1;
      sclk_rise = 1'b0; apply_req = 1'b0; mem_err = 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         reg_rd(row_addr[i], v);
         `CHECK(v, row_exp[i])
      end
      // store refused while writes are protected
      reg_wr(STORE_ADDR, 8'h01);
      reg_rd(BUSY_ADDR, v);
      `CHECK(v, 8'h00)
      `CHECK(i_nvm.mem_q[0], 8'h5a)
      // two bytes from 0x010, then apply, then end
      reg_wr(12'h0a00, 8'h01);
      reg_wr(12'h0a02, 8'h10);
      reg_wr(RELOAD_WREN_ADDR, 8'h01);
      @(posedge core_clk);
      status_sel <= 1'b1;
      reg_wr(STORE_ADDR, 8'h01);
      reg_rd(BUSY_ADDR, v);
      `CHECK(v, 8'h01)
      `CHECK(status_pin, 1'b1)
      reg_rd(STORE_ADDR, v);
      `CHECK(v, 8'h01)
      wait_idle();
      repeat (2) @(posedge core_clk);
      `CHECK(status_pin, 1'b0)
      `CHECK(i_nvm.mem_q[0], 8'h10)
      `CHECK(i_nvm.mem_q[1], 8'h11)
      `CHECK(i_nvm.mem_q[2], 8'h58)
      reg_rd(STORE_ADDR, v);
      `CHECK(v, 8'h00)
      `CHECK(n_apply, 0)
      pulse_sclk();
      `CHECK(n_apply, 1)
      // software apply also waits for a serial clock rise
      @(posedge core_clk);
      apply_req <= 1'b1;
      @(posedge core_clk);
      apply_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHECK(n_apply, 1)
      pulse_sclk();
      `CHECK(n_apply, 2)
      // bad data flagged, then cleared by the next clean transfer
      @(posedge core_clk);
      mem_err <= 1'b1;
      reg_wr(STORE_ADDR, 8'h01);
      wait_idle();
      @(posedge core_clk);
      mem_err <= 1'b0;
      reg_rd(ERROR_ADDR, v);
      `CHECK(v, 8'h01)
      reg_wr(STORE_ADDR, 8'h01);
      wait_idle();
      reg_rd(ERROR_ADDR, v);
      `CHECK(v, 8'h00)
      // reload ignored while the select pin is high
      reg_wr(RELOAD_WREN_ADDR, 8'h03);
      repeat (6) @(posedge core_clk);
      `CHECK(n_sreset, 0)
      @(posedge core_clk);
      mem_sel_pin <= 1'b0;
      reg_wr(12'h0a02, 8'h20);
      repeat (3) @(posedge core_clk);
      reg_wr(RELOAD_WREN_ADDR, 8'h03);
      wait_idle();
      `CHECK(n_sreset, 1)
      `CHECK(i_nvm.buf_q[32], 8'h10)
      `CHECK(i_nvm.buf_q[33], 8'h11)
      reg_rd(RELOAD_WREN_ADDR, v);
      `CHECK(v[1], 1'b0)
      // reset in mid-store restores protection and idles the walker
      reg_wr(RELOAD_WREN_ADDR, 8'h01);
      reg_wr(STORE_ADDR, 8'h01);
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      reg_rd(BUSY_ADDR, v);
      `CHECK(v, 8'h00)
      reg_rd(RELOAD_WREN_ADDR, v);
      `CHECK(v, 8'h00)
      stop_test();
   end
endmodule : testbench
`default_nettype wire
